// ===== hdl/adcsc_pkg.sv
package adcsc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_RES  = 8'h08;
	localparam logic [7:0] OFS_REFH = 8'h0c;
	localparam logic [7:0] OFS_REFL = 8'h10;
	localparam logic [7:0] OFS_CMP  = 8'h14;

	// control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_CONT  = 1;
	localparam int CTRL_EXTEN = 2;
	localparam int CTRL_RC_CLOCK_SELECT = 3;
	localparam int CTRL_CH_LO = 4;
	localparam int CH_W       = 3;

	// status register fields
	localparam int STAT_DONE = 0;
	localparam int STAT_BUSY = 1;

	// compare register fields
	localparam int CMP_EN   = 0;
	localparam int CMP_IE   = 1;
	localparam int CMP_OUT  = 2;
	localparam int CMP_FLAG = 3;

	// reference layout
	localparam int REFL_POS = 6;
	localparam int REFH_W   = 8;
	localparam int REFL_W   = 2;

	// conversion timing in converter clocks
	localparam int RES_W       = 10;
	localparam int CONV_CYC    = 34;
	localparam int SAMPLE_CYC  = 4;
	localparam int BIT_CYC     = 3;
	localparam int CNT_W       = 6;

endpackage : adcsc_pkg

// ===== hdl/adcsc_sar.sv
`timescale 1ns/100ps
module adcsc_sar #(
	parameter int RES_W    = adcsc_pkg::RES_W,
	parameter int CONV_CYC = adcsc_pkg::CONV_CYC
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// control
	input  wire logic             go,
	output logic                  busy_q,
	output logic                  done_q,
	output logic [RES_W-1:0]      result_q,
	// analog core
	input  wire logic             comp_hi,
	output logic [RES_W-1:0]      code_q,
	output logic                  sample_q
);

	localparam logic [adcsc_pkg::CNT_W-1:0] LAST =
		adcsc_pkg::CNT_W'(CONV_CYC - 1);
	localparam logic [adcsc_pkg::CNT_W-1:0] SMP_END =
		adcsc_pkg::CNT_W'(adcsc_pkg::SAMPLE_CYC - 1);
	localparam logic [1:0] PH_END = 2'(adcsc_pkg::BIT_CYC - 1);
	localparam logic [RES_W-1:0] MSB = {1'b1, {(RES_W-1){1'b0}}};

	logic [adcsc_pkg::CNT_W-1:0] cnt_q;
	logic [1:0]                  ph_q;
	logic [RES_W-1:0]            mask_q;
	logic [RES_W-1:0]            kept;

	// trial code after the comparator verdict on the current bit
	assign kept = comp_hi ? code_q : (code_q & ~mask_q);

	// binary search, sample phase then one bit per trial
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			busy_q   <= 1'b0;
			done_q   <= 1'b0;
			result_q <= '0;
			code_q   <= '0;
			sample_q <= 1'b0;
			cnt_q    <= '0;
			ph_q     <= '0;
			mask_q   <= '0;
		end else if (!busy_q) begin
			done_q <= 1'b0;
			if (go) begin
				busy_q   <= 1'b1;
				sample_q <= 1'b1;
				cnt_q    <= '0;
				ph_q     <= '0;
				code_q   <= '0;
				mask_q   <= MSB;
			end
		end else begin
			cnt_q <= cnt_q + 1'b1;
			if (cnt_q == SMP_END) begin
				sample_q <= 1'b0;
				code_q   <= mask_q;
			end else if (cnt_q > SMP_END) begin
				ph_q <= (ph_q == PH_END) ? 2'b00 : ph_q + 1'b1;
				if (ph_q == PH_END) begin
					mask_q <= mask_q >> 1;
					code_q <= kept | (mask_q >> 1);
				end
			end
			if (cnt_q == LAST) begin
				busy_q   <= 1'b0;
				done_q   <= 1'b1;
				result_q <= kept;
			end
		end
	end

endmodule : adcsc_sar

// ===== hdl/adcsc_top.sv
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module adcsc_top #(
	parameter int RES_W    = adcsc_pkg::RES_W,
	parameter int CONV_CYC = adcsc_pkg::CONV_CYC
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// analog converter core
	input  wire logic             comp_hi,
	output logic [RES_W-1:0]      sar_code,
	output logic                  sar_sample,
	output logic [2:0]            sar_channel,
	// external start trigger
	input  wire logic             ext_start,
	// power management
	input  wire logic             idle_bit,
	input  wire logic             power_down_bit,
	output logic                  cpu_wake,
	output logic                  rc_clock_select,
	// converter interrupt request
	output logic                  adc_irq
);

	// sequencer states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_CONV
	} adcsc_state_t;

	adcsc_state_t state_q;

	// control and status registers
	logic                     start_q;
	logic                     cont_q;
	logic                     exten_q;
	logic                     rc_clock_select_q;
	logic [adcsc_pkg::CH_W-1:0] ch_q;
	logic [adcsc_pkg::CH_W-1:0] conv_ch_q;
	logic                     done_flag_q;
	logic [RES_W-1:0]         result_q;
	logic [adcsc_pkg::REFH_W-1:0] refh_q;
	logic [adcsc_pkg::REFL_W-1:0] refl_q;
	logic                     cmp_en_q;
	logic                     cmp_ie_q;
	logic                     cmp_out_q;
	logic                     cmp_flag_q;
	logic                     ext_prev_q;

	// bus outputs
	logic [31:0]              prdata_q;
	logic                     pready_q;
	logic                     pslverr_q;
	logic [31:0]              rd_d;
	logic                     miss_d;

	// wake and interrupt outputs
	logic                     wake_q;
	logic                     irq_q;

	// converter engine
	logic                     sar_busy;
	logic                     sar_done;
	logic [RES_W-1:0]         sar_result;
	logic                     go;
	logic                     ext_rise;
	logic                     store;
	logic                     cmp_new;
	logic [RES_W-1:0]         ref_val;

	// bus decode strobes
	logic                     wr_en;
	logic                     wr_ctrl;
	logic                     wr_stat;
	logic                     wr_refh;
	logic                     wr_refl;
	logic                     wr_cmp;

	assign wr_en   = psel && penable && pwrite && pready_q;
	assign wr_ctrl = wr_en && (paddr == adcsc_pkg::OFS_CTRL);
	assign wr_stat = wr_en && (paddr == adcsc_pkg::OFS_STAT);
	assign wr_refh = wr_en && (paddr == adcsc_pkg::OFS_REFH);
	assign wr_refl = wr_en && (paddr == adcsc_pkg::OFS_REFL);
	assign wr_cmp  = wr_en && (paddr == adcsc_pkg::OFS_CMP);

	// reference assembled from both registers
	assign ref_val = {refh_q, refl_q};

	// start trigger edge on the external pin
	assign ext_rise = exten_q && ext_start && !ext_prev_q;

	// launch only from idle, never while a result is being finished
	assign go = start_q && (state_q == ST_IDLE) && !sar_busy && !sar_done;

	// new result is kept unless an unread single result is still flagged
	assign store = sar_done && (!done_flag_q || cont_q);

	// compare outcome of the incoming result
	assign cmp_new = (sar_result >= ref_val);

	// converter engine
	adcsc_sar #(
		.RES_W    (RES_W),
		.CONV_CYC (CONV_CYC)
	) u_sar (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.go       (go),
		.busy_q   (sar_busy),
		.done_q   (sar_done),
		.result_q (sar_result),
		.comp_hi  (comp_hi),
		.code_q   (sar_code),
		.sample_q (sar_sample)
	);

	// sequencer state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (go) begin
						state_q <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (sar_done) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// channel held for the whole conversion
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			conv_ch_q <= '0;
		end else if (go) begin
			conv_ch_q <= ch_q;
		end
	end

	// external pin history for edge detection
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_start;
		end
	end

	// start bit: software or trigger set, hardware clear at end of a single conversion
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			start_q <= 1'b0;
		end else if (wr_ctrl) begin
			start_q <= pwdata[adcsc_pkg::CTRL_START]; // software write wins
		end else if (ext_rise && !sar_busy) begin
			start_q <= 1'b1;
		end else if (sar_done && !cont_q) begin
			start_q <= 1'b0;
		end
	end

	// mode, trigger enable and channel select
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cont_q  <= 1'b0;
			exten_q <= 1'b0;
			ch_q    <= '0;
		end else if (wr_ctrl) begin
			cont_q  <= pwdata[adcsc_pkg::CTRL_CONT];
			exten_q <= pwdata[adcsc_pkg::CTRL_EXTEN];
			ch_q    <= pwdata[adcsc_pkg::CTRL_CH_LO +: adcsc_pkg::CH_W];
		end
	end

	// rc clock select, frozen while the converter is in use
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rc_clock_select_q <= 1'b0;
		end else if (wr_ctrl && !start_q && !sar_busy) begin
			rc_clock_select_q <= pwdata[adcsc_pkg::CTRL_RC_CLOCK_SELECT];
		end
	end

	// done flag, set wins over software clear
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			done_flag_q <= 1'b0;
		end else if (sar_done) begin
			done_flag_q <= 1'b1;
		end else if (wr_stat && !pwdata[adcsc_pkg::STAT_DONE]) begin
			done_flag_q <= 1'b0;
		end
	end

	// stored conversion result
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			result_q <= '0;
		end else if (store) begin
			result_q <= sar_result;
		end
	end

	// reference value, locked while compare is enabled
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			refh_q <= '0;
			refl_q <= '0;
		end else begin
			if (wr_refh && !cmp_en_q) begin
				refh_q <= pwdata[adcsc_pkg::REFH_W-1:0];
			end
			if (wr_refl && !cmp_en_q) begin
				refl_q <= pwdata[adcsc_pkg::REFL_POS +: adcsc_pkg::REFL_W];
			end
		end
	end

	// compare enables
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmp_en_q <= 1'b0;
			cmp_ie_q <= 1'b0;
		end else if (wr_cmp) begin
			cmp_en_q <= pwdata[adcsc_pkg::CMP_EN];
			cmp_ie_q <= pwdata[adcsc_pkg::CMP_IE];
		end
	end

	// compare output bit follows each stored result while compare is enabled
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmp_out_q <= 1'b0;
		end else if (store && cmp_en_q) begin
			cmp_out_q <= cmp_new;
		end
	end

	// compare change flag, cleared only by writing zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmp_flag_q <= 1'b0;
		end else if (store && cmp_en_q && (cmp_new != cmp_out_q)) begin
			cmp_flag_q <= 1'b1;
		end else if (wr_cmp && !pwdata[adcsc_pkg::CMP_FLAG]) begin
			cmp_flag_q <= 1'b0;
		end
	end

	// converter interrupt request level
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= done_flag_q || (cmp_flag_q && cmp_ie_q);
		end
	end

	// wake pulse when a conversion ends while the cpu sleeps
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= sar_done && (idle_bit || power_down_bit);
		end
	end

	// read data and unmapped detection
	always_comb begin
		rd_d   = '0;
		miss_d = 1'b0;
		if (paddr == adcsc_pkg::OFS_CTRL) begin
			rd_d[adcsc_pkg::CTRL_START] = start_q;
			rd_d[adcsc_pkg::CTRL_CONT]  = cont_q;
			rd_d[adcsc_pkg::CTRL_EXTEN] = exten_q;
			rd_d[adcsc_pkg::CTRL_RC_CLOCK_SELECT] = rc_clock_select_q;
			rd_d[adcsc_pkg::CTRL_CH_LO +: adcsc_pkg::CH_W] = ch_q;
		end else if (paddr == adcsc_pkg::OFS_STAT) begin
			rd_d[adcsc_pkg::STAT_DONE] = done_flag_q;
			rd_d[adcsc_pkg::STAT_BUSY] = sar_busy;
		end else if (paddr == adcsc_pkg::OFS_RES) begin
			rd_d[RES_W-1:0] = result_q;
		end else if (paddr == adcsc_pkg::OFS_REFH) begin
			rd_d[adcsc_pkg::REFH_W-1:0] = refh_q;
		end else if (paddr == adcsc_pkg::OFS_REFL) begin
			rd_d[adcsc_pkg::REFL_POS +: adcsc_pkg::REFL_W] = refl_q;
		end else if (paddr == adcsc_pkg::OFS_CMP) begin
			rd_d[adcsc_pkg::CMP_EN]   = cmp_en_q;
			rd_d[adcsc_pkg::CMP_IE]   = cmp_ie_q;
			rd_d[adcsc_pkg::CMP_OUT]  = cmp_out_q;
			rd_d[adcsc_pkg::CMP_FLAG] = cmp_flag_q; // reading leaves it set
		end else begin
			miss_d = 1'b1;
		end
	end

	// apb answer, ready in the first access cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready_q  <= 1'b0;
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else if (psel && !penable && !pready_q) begin
			pready_q  <= 1'b1;
			prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
			pslverr_q <= miss_d;
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// outputs straight from flip-flops
	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign sar_channel     = conv_ch_q;
	assign cpu_wake        = wake_q;
	assign rc_clock_select = rc_clock_select_q;
	assign adc_irq         = irq_q;

endmodule : adcsc_top

// ===== dv/adcsc_properties.sv
`timescale 1ns/100ps
module adcsc_properties #(
	parameter int RES_W    = 10,
	parameter int CONV_CYC = 34
) (
	// clock and reset
	input wire logic             sys_clk,
	input wire logic             reset,
	// apb handshake
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pready,
	// converter core and power
	input wire logic [RES_W-1:0] sar_code,
	input wire logic             sar_sample,
	input wire logic             idle_bit,
	input wire logic             power_down_bit,
	input wire logic             cpu_wake,
	input wire logic             adc_irq
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// cycles since the previous start of sampling
	logic       samp_q;
	logic [5:0] since_q;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			samp_q  <= 1'b0;
			since_q <= 6'h3f;
		end else begin
			samp_q <= sar_sample;
			if (sar_sample && !samp_q)
				since_q <= 6'h01;
			else if (since_q != 6'h3f)
				since_q <= since_q + 6'h01;
		end
	end

	apb_ready_a:
		assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");
	sample_len_a:
		assert property ($rose(sar_sample) |-> sar_sample[*4] ##1 !sar_sample)
		else $error("sampling not four cycles");
	first_trial_a:
		assert property ($fell(sar_sample) |-> sar_code == 10'h200 ##1 $stable(sar_code)[*2])
		else $error("first trial code wrong");
	conv_len_a:
		assert property ($rose(sar_sample) && !adc_irq |-> ##30 !adc_irq ##[4:6] adc_irq)
		else $error("conversion length wrong");
	no_restart_a:
		assert property ($rose(sar_sample) |-> since_q >= 6'(CONV_CYC))
		else $error("conversion restarted early");
	wake_cause_a:
		assert property (cpu_wake |-> $past(idle_bit) || $past(power_down_bit))
		else $error("wake outside sleep");
	wake_pulse_a:
		assert property (cpu_wake |=> !cpu_wake)
		else $error("wake longer than one cycle");
	wake_irq_a:
		assert property ($rose(cpu_wake) |-> ##[0:2] adc_irq)
		else $error("wake without request");

	// main scenarios reached
	cover property ($rose(cpu_wake));
	cover property ($rose(sar_sample) && since_q == 6'd36);
	cover property ($fell(adc_irq));
endmodule : adcsc_properties

bind adcsc_top adcsc_properties #(.RES_W(RES_W), .CONV_CYC(CONV_CYC)) u_props (
	.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
	.pready(pready), .sar_code(sar_code), .sar_sample(sar_sample),
	.idle_bit(idle_bit), .power_down_bit(power_down_bit), .cpu_wake(cpu_wake),
	.adc_irq(adc_irq)
);

// ===== dv/adcsc_core_model.sv
`timescale 1ns/100ps
module adcsc_core_model #(
	parameter int VREF_MV = 3300
) (
	// converter core side
	input  wire logic [9:0]  sar_code,
	input  wire logic        sar_sample,
	input  wire logic [2:0]  sar_channel,
	input  wire logic [15:0] vin_mv [8],
	output logic             comp_hi
);
	// ideal ladder; output meaningless while sampling
	always_comb begin
		comp_hi = 32'(vin_mv[sar_channel]) * 1024 >= 32'(sar_code) * VREF_MV;
		if (sar_sample)
			comp_hi = ~comp_hi;
	end
endmodule : adcsc_core_model

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
	// bench signals
	logic        sys_clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        comp_hi;
	logic [9:0]  sar_code;
	logic        sar_sample;
	logic [2:0]  sar_channel;
	logic        ext_start;
	logic        idle_bit;
	logic        power_down_bit;
	logic        cpu_wake;
	logic        rc_clock_select;
	logic        adc_irq;
	logic [15:0] vin [8];
	logic [31:0] rd;
	logic        err;
	int          failures;
	int          tests_run;
	int          n;
	int          mv [4] = '{0, 1000, 1650, 3299};
	logic [9:0]  cd [4] = '{10'h000, 10'h136, 10'h200, 10'h3ff};

	adcsc_top dut (
		.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comp_hi(comp_hi), .sar_code(sar_code),
		.sar_sample(sar_sample), .sar_channel(sar_channel), .ext_start(ext_start),
		.idle_bit(idle_bit), .power_down_bit(power_down_bit), .cpu_wake(cpu_wake),
		.rc_clock_select(rc_clock_select), .adc_irq(adc_irq)
	);
	adcsc_core_model u_core (
		.sar_code(sar_code), .sar_sample(sar_sample), .sar_channel(sar_channel),
		.vin_mv(vin), .comp_hi(comp_hi)
	);

	// clock
	always #50 sys_clk = ~sys_clk;

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	// poll until the done flag shows
	task automatic wdone();
		int k;
		k = 0;
		do begin
			apb(1'b0, adcsc_pkg::OFS_STAT, 32'h0);
			k++;
		end while (rd[adcsc_pkg::STAT_DONE] !== 1'b1 && k < 40);
		if (k >= 40) begin
			failures++;
			tally_and_finish();
		end
	endtask : wdone

	// settle, compare request level, back to a rising edge
	task automatic irq_is(input logic e);
		repeat (2) @(negedge sys_clk);
		chk({31'h0, adc_irq}, {31'h0, e});
		@(posedge sys_clk);
	endtask : irq_is

	// verdict
	task automatic tally_and_finish();
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		{psel, penable, pwrite, ext_start, idle_bit, power_down_bit} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		failures = 0;
		tests_run = 0;
		for (int i = 0; i < 8; i++)
			vin[i] = 16'h0;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		// reset values and an unmapped word
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b1, 8'h18, 32'hffffffff);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h0);
		// single conversions over the range, retriggered while busy
		for (int i = 0; i < 4; i++) begin
			vin[i] <= 16'(mv[i]);
			apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h5 | (32'(i) << 4));
			apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h5 | (32'(i) << 4));
			ext_start <= 1'b1;
			wdone();
			ext_start <= 1'b0;
			apb(1'b0, adcsc_pkg::OFS_RES, 32'h0);
			chk(rd, {22'h0, cd[i]});
			apb(1'b0, adcsc_pkg::OFS_CTRL, 32'h0);
			chk(rd, 32'h4 | (32'(i) << 4));
			if (i < 3)
				apb(1'b1, adcsc_pkg::OFS_STAT, 32'h0);
		end
		// result kept while done stays set
		apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h1);
		repeat (40) @(posedge sys_clk);
		apb(1'b0, adcsc_pkg::OFS_RES, 32'h0);
		chk(rd, 32'h3ff);
		apb(1'b1, adcsc_pkg::OFS_STAT, 32'h0);
		// continuous mode on channel one
		apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h13);
		wdone();
		vin[1] <= 16'd1650;
		repeat (80) @(posedge sys_clk);
		apb(1'b0, adcsc_pkg::OFS_RES, 32'h0);
		chk(rd, 32'h200);
		apb(1'b0, adcsc_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h13);
		apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h11);
		repeat (80) @(posedge sys_clk);
		apb(1'b0, adcsc_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h10);
		apb(1'b1, adcsc_pkg::OFS_STAT, 32'h0);
		// reference layout, write lock, change flag
		apb(1'b1, adcsc_pkg::OFS_REFH, 32'h80);
		apb(1'b1, adcsc_pkg::OFS_REFL, 32'hff);
		apb(1'b1, adcsc_pkg::OFS_CMP, 32'h3);
		apb(1'b1, adcsc_pkg::OFS_REFH, 32'hff);
		apb(1'b0, adcsc_pkg::OFS_REFH, 32'h0);
		chk(rd, 32'h80);
		apb(1'b0, adcsc_pkg::OFS_REFL, 32'h0);
		chk(rd, 32'hc0);
		apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h31);
		wdone();
		apb(1'b0, adcsc_pkg::OFS_CMP, 32'h0);
		chk(rd, 32'hf);
		apb(1'b1, adcsc_pkg::OFS_STAT, 32'h0);
		irq_is(1'b1);
		apb(1'b0, adcsc_pkg::OFS_CMP, 32'h0);
		chk(rd, 32'hf);
		apb(1'b1, adcsc_pkg::OFS_CMP, 32'h1);
		apb(1'b0, adcsc_pkg::OFS_CMP, 32'h0);
		chk(rd, 32'h5);
		apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h21);
		wdone();
		apb(1'b0, adcsc_pkg::OFS_CMP, 32'h0);
		chk(rd, 32'h9);
		apb(1'b1, adcsc_pkg::OFS_STAT, 32'h0);
		irq_is(1'b0);
		// wake from power-down, then from idle
		apb(1'b1, adcsc_pkg::OFS_CMP, 32'h0);
		apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h8);
		chk({31'h0, rc_clock_select}, 32'h1);
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h9);
			{idle_bit, power_down_bit} <= 2'(s + 1);
			n = 0;
			while (cpu_wake !== 1'b1 && n < 60) begin
				@(posedge sys_clk);
				n++;
			end
			chk(32'(n < 60), 32'h1);
			if (n >= 60)
				tally_and_finish();
			irq_is(1'b1);
			{idle_bit, power_down_bit} <= 2'b00;
			apb(1'b1, adcsc_pkg::OFS_STAT, 32'h0);
		end
		// external trigger starts a conversion on its own
		apb(1'b1, adcsc_pkg::OFS_CTRL, 32'h24);
		ext_start <= 1'b1;
		wdone();
		ext_start <= 1'b0;
		apb(1'b0, adcsc_pkg::OFS_RES, 32'h0);
		chk(rd, 32'h200);
		apb(1'b0, adcsc_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h24);
		tally_and_finish();
	end
endmodule : tb
